/* verilog/pcop_port.sv */
// Top of the converter's parallel output port with a register port.
// Assumes all pins synchronous to clk; pads resolve data_oe.
//
// The address map and the address-and-strobe port were left to the implementer.
module pcop_port
  import pcop_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic signed [POS_W-1:0] transducer_position,
  input wire logic resolution_select,
  input wire logic output_freeze_n,
  input wire logic upper_byte_enable_n,
  input wire logic lower_byte_enable_n,
  output logic [POS_W-1:0] data_out,
  output logic [POS_W-1:0] data_oe,
  output logic fault_n,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [DATA_W-1:0] reg_rdata,
  output logic irq
);

  localparam int settle_cyc = FREEZE_SETTLE_CYC;

  logic signed [POS_W-1:0] position;
  logic res_14_active;
  logic [POS_W-1:0] hold_reg;
  logic [POS_W-1:0] hold_next;
  logic [POS_W-1:0] mapped_word;
  logic fault_n_prev_reg;
  logic [EVT_W-1:0] events;
  logic [EVT_W-1:0] status_reg;
  logic [EVT_W-1:0] status_next;
  logic [EVT_W-1:0] mask_reg;
  logic [EVT_W-1:0] mask_next;
  logic [EVT_W-1:0] w1c;
  logic irq_reg;
  logic irq_next;
  logic [DATA_W-1:0] rdata_reg;
  logic [DATA_W-1:0] rdata_next;
  logic [DATA_W-1:0] read_mux;
  logic wr_status;
  logic wr_mask;
  logic [DATA_W-1:0] flags_word;
  // Lane outputs, joined onto the pins below
  logic [UPPER_W-1:0] upper_q;
  logic [UPPER_W-1:0] upper_oe;
  logic [LOWER_W-1:0] lower_q;
  logic [LOWER_W-1:0] lower_oe;

  // external strap, checked inside the loop
  pcop_track_loop u_loop (
    .clk(clk),
    .reset(reset),
    .transducer_position(transducer_position),
    .resolution_select(resolution_select),
    .position_reg(position),
    .fault_n_reg(fault_n),
    .res_14_active(res_14_active)
  );

  // MSB on bit 1, coarse LSBs zero-filled
  assign mapped_word = res_14_active ? position :
                       {position[POS_W-1:RES_DROP], DROP_FILL};

  assign hold_next = output_freeze_n ? mapped_word : hold_reg;

  always_ff @(posedge clk)
  begin
    if (reset)
      hold_reg <= '0;
    else
      hold_reg <= hold_next;
  end

  pcop_byte_lane #(.W(UPPER_W)) u_upper (
    .clk(clk),
    .reset(reset),
    .enable_n(upper_byte_enable_n),
    .data(hold_reg[POS_W-1:LOWER_W]),
    .q_reg(upper_q),
    .oe_reg(upper_oe)
  );

  pcop_byte_lane #(.W(LOWER_W)) u_lower (
    .clk(clk),
    .reset(reset),
    .enable_n(lower_byte_enable_n),
    .data(hold_reg[LOWER_W-1:0]),
    .q_reg(lower_q),
    .oe_reg(lower_oe)
  );

  // One driver per pin vector, upper lane on top
  assign data_out = {upper_q, lower_q};
  assign data_oe = {upper_oe, lower_oe};

  // Fault edges become interrupt events
  assign events[EVT_FAULT_SET] = fault_n_prev_reg & ~fault_n;
  assign events[EVT_FAULT_CLR] = ~fault_n_prev_reg & fault_n;

  assign wr_status = reg_write && (reg_addr == ADDR_STATUS);
  assign wr_mask = reg_write && (reg_addr == ADDR_MASK);
  assign w1c = wr_status ? reg_wdata[EVT_W-1:0] : EVT_RESET;
  // Set beats a same-cycle clear so no edge is lost
  assign status_next = (status_reg & ~w1c) | events;
  assign mask_next = wr_mask ? reg_wdata[EVT_W-1:0] : mask_reg;
  assign irq_next = |(status_next & mask_next);

  assign flags_word = DATA_W'({res_14_active, ~output_freeze_n, fault_n});

  always_comb
  begin
    if (reg_addr == ADDR_STATUS)
      read_mux = DATA_W'(status_reg);
    else if (reg_addr == ADDR_MASK)
      read_mux = DATA_W'(mask_reg);
    else if (reg_addr == ADDR_POSITION)
      read_mux = DATA_W'(position);
    else if (reg_addr == ADDR_FLAGS)
      read_mux = flags_word;
    else
      read_mux = RDATA_IDLE;
  end

  // Data stands for one cycle only, idle zero otherwise
  assign rdata_next = reg_read ? read_mux : RDATA_IDLE;

  // Idle level high, so no false edge after reset
  always_ff @(posedge clk)
  begin
    if (reset)
      fault_n_prev_reg <= 1'b1;
    else
      fault_n_prev_reg <= fault_n;
  end

  always_ff @(posedge clk)
  begin
    if (reset)
      status_reg <= EVT_RESET;
    else
      status_reg <= status_next;
  end

  always_ff @(posedge clk)
  begin
    if (reset)
      mask_reg <= MASK_RESET;
    else
      mask_reg <= mask_next;
  end

  // Registered so the pin never glitches on a decode
  always_ff @(posedge clk)
  begin
    if (reset)
      irq_reg <= 1'b0;
    else
      irq_reg <= irq_next;
  end

  always_ff @(posedge clk)
  begin
    if (reset)
      rdata_reg <= RDATA_IDLE;
    else
      rdata_reg <= rdata_next;
  end

  assign irq = irq_reg;
  assign reg_rdata = rdata_reg;

  default clocking @(posedge clk); endclocking
  default disable iff (reset);

  sequence s_upper_on;
    !upper_byte_enable_n;
  endsequence

  property p_upper_lane;
    s_upper_on |=> data_oe[POS_W-1:LOWER_W] == {UPPER_W{1'b1}}
      && data_out[POS_W-1:LOWER_W] == $past(hold_reg[POS_W-1:LOWER_W]);
  endproperty
  a_upper_lane: assert property (p_upper_lane)
    else $error("upper lane not driven with held word");

  property p_upper_float;
    upper_byte_enable_n |=> data_oe[POS_W-1:LOWER_W] == '0;
  endproperty
  a_upper_float: assert property (p_upper_float)
    else $error("upper lane driven while disabled");

  property p_lower_lane;
    !lower_byte_enable_n |=> data_oe[LOWER_W-1:0] == {LOWER_W{1'b1}}
      && data_out[LOWER_W-1:0] == $past(hold_reg[LOWER_W-1:0]);
  endproperty
  a_lower_lane: assert property (p_lower_lane)
    else $error("lower lane enable not followed");

  property p_lower_float;
    lower_byte_enable_n |=> data_oe[LOWER_W-1:0] == '0;
  endproperty
  a_lower_float: assert property (p_lower_float)
    else $error("lower lane driven while disabled");

  sequence s_freeze_held;
    $fell(output_freeze_n) ##1 !output_freeze_n [*2];
  endsequence

  property p_freeze_stable;
    s_freeze_held |-> $stable(data_out);
  endproperty
  a_freeze_stable: assert property (p_freeze_stable)
    else $error("output word moved while frozen");

  property p_freeze_settle;
    $fell(output_freeze_n) ##0 !output_freeze_n [*2]
      |-> ##[1:settle_cyc] data_out == hold_reg;
  endproperty
  a_freeze_settle: assert property (p_freeze_settle)
    else $error("output word not valid within settling time");

  property p_hold_frozen;
    !output_freeze_n |=> hold_reg == $past(hold_reg);
  endproperty
  a_hold_frozen: assert property (p_hold_frozen)
    else $error("holding register loaded while frozen");

  property p_msb;
    output_freeze_n |=> hold_reg[POS_W-1] == $past(position[POS_W-1]);
  endproperty
  a_msb: assert property (p_msb)
    else $error("bit 1 is not the position MSB");

  property p_coarse_word;
    output_freeze_n && !res_14_active |=>
      hold_reg == {$past(position[POS_W-1:RES_DROP]), DROP_FILL};
  endproperty
  a_coarse_word: assert property (p_coarse_word)
    else $error("12-bit word misplaced");

  property p_fine_word;
    output_freeze_n && res_14_active |=> hold_reg == $past(position);
  endproperty
  a_fine_word: assert property (p_fine_word)
    else $error("14-bit word misplaced");

  // Set wins, so a falling flag always leaves a trace
  property p_fault_event;
    fault_n_prev_reg && !fault_n |=> status_reg[EVT_FAULT_SET];
  endproperty
  a_fault_event: assert property (p_fault_event)
    else $error("fault event not recorded");

  property p_settle_event;
    !fault_n_prev_reg && fault_n |=> status_reg[EVT_FAULT_CLR];
  endproperty
  a_settle_event: assert property (p_settle_event)
    else $error("settle event not recorded");

  property p_event_clear;
    wr_status && reg_wdata[EVT_FAULT_SET] && !events[EVT_FAULT_SET]
      |=> !status_reg[EVT_FAULT_SET];
  endproperty
  a_event_clear: assert property (p_event_clear)
    else $error("fault event survived its clear");

  property p_irq_level;
    irq == |(status_reg & mask_reg);
  endproperty
  a_irq_level: assert property (p_irq_level)
    else $error("interrupt does not follow masked status");

  sequence s_read_position;
    reg_read && (reg_addr == ADDR_POSITION);
  endsequence

  // Counter read back sign-extended
  property p_position_read;
    s_read_position |=> reg_rdata == DATA_W'($past(position));
  endproperty
  a_position_read: assert property (p_position_read)
    else $error("position read lost its sign");

endmodule

/* inc/pcop_pkg.sv */
// Constants shared by the position output port and its helpers.
// Assumes a single 10 MHz clock and a synchronous active-high reset.
package pcop_pkg;

  // Position word
  localparam int POS_W = 14;
  localparam int ERR_W = POS_W + 1;
  localparam int UPPER_W = 6;
  localparam int LOWER_W = 8;
  localparam int RES_DROP = 2;
  localparam logic signed [POS_W-1:0] POS_MAX = 14'sh1fff;
  localparam logic signed [POS_W-1:0] POS_MIN = 14'sh2000;
  localparam logic [RES_DROP-1:0] DROP_FILL = 2'h0;

  // Tracking loop
  localparam int FAULT_LSBS = 65;
  localparam logic signed [ERR_W-1:0] STEP_FINE = 15'sh0001;
  localparam logic signed [ERR_W-1:0] STEP_COARSE = 15'sh0004;
  localparam logic [ERR_W-1:0] THR_FINE = ERR_W'(FAULT_LSBS);
  localparam logic [ERR_W-1:0] THR_COARSE = ERR_W'(FAULT_LSBS << RES_DROP);

  // Timing
  localparam int CLK_PERIOD_NS = 100;
  localparam int FREEZE_SETTLE_NS = 500;
  localparam int FREEZE_SETTLE_CYC =
    (FREEZE_SETTLE_NS / CLK_PERIOD_NS) < 1 ? 1 :
    (FREEZE_SETTLE_NS / CLK_PERIOD_NS);

  // Register port
  localparam int ADDR_W = 4;
  localparam int DATA_W = 16;
  localparam int EVT_W = 2;
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 4'h0;
  localparam logic [ADDR_W-1:0] ADDR_MASK = 4'h1;
  localparam logic [ADDR_W-1:0] ADDR_POSITION = 4'h2;
  localparam logic [ADDR_W-1:0] ADDR_FLAGS = 4'h3;
  localparam int EVT_FAULT_SET = 0;
  localparam int EVT_FAULT_CLR = 1;
  localparam logic [EVT_W-1:0] EVT_RESET = 2'h0;
  localparam logic [EVT_W-1:0] MASK_RESET = 2'h0;
  localparam logic [DATA_W-1:0] RDATA_IDLE = 16'h0000;

  // Clamp a widened sum back into the two's-complement range
  function automatic logic signed [POS_W-1:0] pcop_sat
    (input logic signed [ERR_W-1:0] v);
    logic signed [POS_W-1:0] r;
    r = v[POS_W-1:0];
    if (v > ERR_W'(POS_MAX))
      r = POS_MAX;
    else if (v < ERR_W'(POS_MIN))
      r = POS_MIN;
    return r;
  endfunction

endpackage

/* verilog/pcop_byte_lane.sv */
// One three-state byte lane of the parallel output.
// Assumes the enable is synchronous to clk; the pad resolves oe.
module pcop_byte_lane
  import pcop_pkg::*;
#(
  parameter int W = LOWER_W
)
(
  input wire logic clk,
  input wire logic reset,
  input wire logic enable_n,
  input wire logic [W-1:0] data,
  output logic [W-1:0] q_reg,
  output logic [W-1:0] oe_reg
);

  logic [W-1:0] oe_next;

  assign oe_next = {W{~enable_n}};

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      q_reg <= '0;
      oe_reg <= '0;
    end
    else
    begin
      q_reg <= data;
      oe_reg <= oe_next;
    end
  end

endmodule

/* verilog/pcop_track_loop.sv */
// Digital tracking counter with saturation and error flag.
// Assumes the transducer position arrives as a synchronous word.
module pcop_track_loop
  import pcop_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic signed [POS_W-1:0] transducer_position,
  input wire logic resolution_select,
  output logic signed [POS_W-1:0] position_reg,
  output logic fault_n_reg,
  output logic res_14_active
);

  logic signed [ERR_W-1:0] error;
  logic [ERR_W-1:0] error_mag;
  logic signed [ERR_W-1:0] step;
  logic signed [ERR_W-1:0] delta;
  logic [ERR_W-1:0] threshold;
  logic signed [POS_W-1:0] position_next;
  logic fault_n_next;
  logic sel_14_reg;
  logic sel_14_next;

  assign res_14_active = resolution_select & fault_n_reg;
  assign step = res_14_active ? STEP_FINE : STEP_COARSE;
  // threshold of strapped mode
  // Held while faulted, else the strap drops it and the flag chatters
  assign sel_14_next = fault_n_reg ? resolution_select : sel_14_reg;
  assign threshold = sel_14_reg ? THR_FINE : THR_COARSE;

  assign error = ERR_W'(transducer_position) - ERR_W'(position_reg);
  assign error_mag = error[ERR_W-1] ? ERR_W'(-error) : ERR_W'(error);
  assign delta = (error > step) ? step :
                 (error < -step) ? -step : error;
  assign position_next = pcop_sat(ERR_W'(position_reg) + delta);
  assign fault_n_next = (error_mag > threshold) ? 1'b0 : 1'b1;

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      position_reg <= '0;
      fault_n_reg <= 1'b1;
      sel_14_reg <= 1'b0;
    end
    else
    begin
      position_reg <= position_next;
      fault_n_reg <= fault_n_next;
      sel_14_reg <= sel_14_next;
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (reset);

  property p_fault_set;
    error_mag > threshold |=> !fault_n_reg;
  endproperty
  a_fault_set: assert property (p_fault_set)
    else $error("fault flag not set on large error");

  property p_fault_clear;
    error_mag <= threshold |=> fault_n_reg;
  endproperty
  a_fault_clear: assert property (p_fault_clear)
    else $error("fault flag not released after settling");

  property p_coarse_on_fault;
    !fault_n_reg && (error > STEP_COARSE) |=>
      ERR_W'(position_reg) - ERR_W'($past(position_reg)) == STEP_COARSE;
  endproperty
  a_coarse_on_fault: assert property (p_coarse_on_fault)
    else $error("fine steps used while faulted");

  property p_bounded_move;
    ##1 (ERR_W'(position_reg) - ERR_W'($past(position_reg)) <= STEP_COARSE)
    && (ERR_W'($past(position_reg)) - ERR_W'(position_reg) <= STEP_COARSE);
  endproperty
  a_bounded_move: assert property (p_bounded_move)
    else $error("counter jumped or wrapped");

endmodule

/* tb/pcop_host_model.sv */
// Host processor model reading the two-byte parallel position word.
// Assumes the port's clk; drives freeze and byte enables after edges.
module pcop_host_model
  import pcop_pkg::*;
(
  input wire logic clk,
  input wire logic [POS_W-1:0] data_out,
  input wire logic [POS_W-1:0] data_oe,
  output logic output_freeze_n,
  output logic upper_byte_enable_n,
  output logic lower_byte_enable_n
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [POS_W-1:0] pins;

  // Released pins show the inverse, so a stale value never matches
  assign pins = data_out ^ ~data_oe;

  initial
  begin
    output_freeze_n = 1'b1;
    upper_byte_enable_n = 1'b1;
    lower_byte_enable_n = 1'b1;
  end

  task automatic read_word(input logic ue_n, input logic le_n,
    input int linger, output logic [POS_W-1:0] w,
    output logic [POS_W-1:0] oe);
    @(posedge clk);
    output_freeze_n <= 1'b0;
    repeat (FREEZE_SETTLE_CYC + linger) @(posedge clk);
    upper_byte_enable_n <= ue_n;
    lower_byte_enable_n <= le_n;
    repeat (2) @(posedge clk);
    w = pins;
    oe = data_oe;
    upper_byte_enable_n <= 1'b1;
    lower_byte_enable_n <= 1'b1;
    output_freeze_n <= 1'b1;
  endtask
endmodule

/* tb/tb_top.sv */
// Self-checking bench for the position output port.
// Assumes a host model on the parallel side and a strobe register bus.
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin \
  miscompares++; $display("[FAIL] %s exp %h got %h", n, e, g); end end
module tb_top;
  import pcop_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, reset, mode14, resolution_select, fault_n, irq;
  logic reg_write, reg_read;
  logic signed [POS_W-1:0] transducer_position;
  logic [POS_W-1:0] data_out, data_oe, w, oe;
  logic output_freeze_n, upper_byte_enable_n, lower_byte_enable_n;
  logic [ADDR_W-1:0] reg_addr;
  logic [DATA_W-1:0] reg_wdata, reg_rdata, rd;
  int miscompares = 0;
  int tests_run = 0;
  int cycles = 0;

  // Board strap: 14-bit mode ties the select to the fault flag
  assign resolution_select = mode14 ? fault_n : 1'b0;

  pcop_port i_pcop_port (.clk(clk), .reset(reset),
    .transducer_position(transducer_position),
    .resolution_select(resolution_select),
    .output_freeze_n(output_freeze_n),
    .upper_byte_enable_n(upper_byte_enable_n),
    .lower_byte_enable_n(lower_byte_enable_n), .data_out(data_out),
    .data_oe(data_oe), .fault_n(fault_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
    .reg_rdata(reg_rdata), .irq(irq));
  pcop_host_model i_pcop_host_model (.clk(clk), .data_out(data_out),
    .data_oe(data_oe), .output_freeze_n(output_freeze_n),
    .upper_byte_enable_n(upper_byte_enable_n),
    .lower_byte_enable_n(lower_byte_enable_n));

  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task automatic tally_and_finish();
    if (miscompares == 0 && tests_run > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // Ceiling well above the two long slews of the run
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 30000)
    begin
      miscompares++;
      tally_and_finish();
    end
  end

  task automatic reg_wr(input logic [ADDR_W-1:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clk);
    reg_write <= 1'b0;
  endtask

  task automatic reg_rd(input logic [ADDR_W-1:0] a, output logic [15:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clk);
    reg_read <= 1'b0;
    @(posedge clk);
    d = reg_rdata;
  endtask

  // Step the input, expect a fault within 3 cycles, then wait to settle
  task automatic step_to(input logic [POS_W-1:0] p);
    int n;
    @(posedge clk);
    transducer_position <= p;
    repeat (3) @(posedge clk);
    `CHK("fault_low", 1'b0, fault_n)
    for (n = 0; n < 4000 && fault_n !== 1'b1; n++) @(posedge clk);
    repeat (300) @(posedge clk);
    `CHK("fault_back", 1'b1, fault_n)
  endtask

  task automatic t_track14();
    step_to(14'sh0064);
    `CHK("irq_masked", 1'b0, irq)
    i_pcop_host_model.read_word(1'b0, 1'b0, 0, w, oe);
    `CHK("word14", 14'h0064, w)
    `CHK("oe_both", 14'h3fff, oe)
    reg_rd(ADDR_POSITION, rd);
    `CHK("pos_reg", 16'h0064, rd)
    reg_rd(ADDR_FLAGS, rd);
    `CHK("flags14", 16'h0005, rd)
    reg_rd(ADDR_STATUS, rd);
    `CHK("status", 16'h0003, rd)
    reg_wr(ADDR_STATUS, 16'h0003);
    reg_rd(ADDR_STATUS, rd);
    `CHK("status_clr", 16'h0000, rd)
  endtask

  task automatic t_bytes_freeze();
    i_pcop_host_model.read_word(1'b0, 1'b1, 0, w, oe);
    `CHK("oe_upper", 14'h3f00, oe)
    `CHK("upper", 6'h00, w[13:8])
    i_pcop_host_model.read_word(1'b1, 1'b0, 0, w, oe);
    `CHK("oe_lower", 14'h00ff, oe)
    `CHK("lower", 8'h64, w[7:0])
    fork
      i_pcop_host_model.read_word(1'b0, 1'b0, 20, w, oe);
      begin
        repeat (3) @(posedge clk);
        transducer_position <= 14'sh0070;
      end
    join
    `CHK("frozen", 14'h0064, w)
    repeat (40) @(posedge clk);
    i_pcop_host_model.read_word(1'b0, 1'b0, 0, w, oe);
    `CHK("resumed", 14'h0070, w)
  endtask

  task automatic t_fault_irq();
    reg_wr(ADDR_MASK, 16'h0003);
    @(posedge clk);
    transducer_position <= POS_MIN;
    repeat (4) @(posedge clk);
    `CHK("irq_set", 1'b1, irq)
    reg_rd(ADDR_FLAGS, rd);
    `CHK("flags_fault", 16'h0000, rd)
    step_to(POS_MIN);
    reg_rd(ADDR_POSITION, rd);
    `CHK("pos_min", 16'he000, rd)
    i_pcop_host_model.read_word(1'b0, 1'b0, 0, w, oe);
    `CHK("word_min", 14'h2000, w)
    reg_wr(ADDR_STATUS, 16'h0003);
    repeat (2) @(posedge clk);
    `CHK("irq_clr", 1'b0, irq)
  endtask

  task automatic t_res12_regs();
    mode14 <= 1'b0;
    step_to(14'sh3ff9);
    i_pcop_host_model.read_word(1'b0, 1'b0, 0, w, oe);
    `CHK("word12", 14'h3ff8, w)
    reg_rd(ADDR_FLAGS, rd);
    `CHK("flags12", 16'h0001, rd)
    reg_wr(ADDR_FLAGS, 16'hffff);
    reg_rd(ADDR_FLAGS, rd);
    `CHK("flags_ro", 16'h0001, rd)
    reg_rd(4'hf, rd);
    `CHK("unmapped", 16'h0000, rd)
  endtask

  initial
  begin
    reset = 1'b1;
    mode14 = 1'b1;
    transducer_position = 14'sh0000;
    reg_addr = 4'h0;
    reg_wdata = 16'h0000;
    reg_write = 1'b0;
    reg_read = 1'b0;
    repeat (8) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    `CHK("rst_fault", 1'b1, fault_n)
    `CHK("rst_oe", 14'h0000, data_oe)
    `CHK("rst_irq", 1'b0, irq)
    t_track14();
    t_bytes_freeze();
    t_fault_irq();
    t_res12_regs();
    tally_and_finish();
  end
endmodule
